// ### logic/wwdt_pkg.sv
// wwdt_pkg: constants and carrier types of the windowed watchdog timer
// assumes a 10 MHz pclk and software access over APB with 32-bit data
package wwdt_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// clocks and timing
	localparam int unsigned PCLK_HZ         = 10_000_000;
	localparam int unsigned LOW_POWER_RC_OSC_HZ         = 32_000;
	localparam int unsigned LOW_POWER_RC_OSC_DIV_CYCLES = PCLK_HZ / LOW_POWER_RC_OSC_HZ;
	localparam int unsigned LOW_POWER_RC_OSC_DIV_W      = 9;
	localparam int unsigned PRESCALE_32_LOG = 5;
	localparam int unsigned PRESCALE_128_LOG = 7;
	localparam int unsigned ELAPSED_W       = 23;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_RESET_CONTROL_REG   = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MASK   = 8'h0C;
	localparam logic [7:0] OFS_COUNT  = 8'h10;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int unsigned RESET_CONTROL_REG_IDLE_BIT     = 2;
	localparam int unsigned RESET_CONTROL_REG_SLEEP_BIT    = 3;
	localparam int unsigned RESET_CONTROL_REG_TIMEOUT_BIT  = 4;
	localparam int unsigned RESET_CONTROL_REG_SOFT_EN_BIT  = 5;
	localparam int unsigned ST_TIMEOUT_BIT    = 0;
	localparam int unsigned ST_WINDOW_BIT     = 1;
	localparam int unsigned ST_WAKE_BIT       = 2;
	localparam int unsigned ST_W              = 3;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0]      CONFIG_RESET = 8'h7F;
	localparam logic [ST_W-1:0] MASK_RESET   = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic       hard_enable;
		logic       window_disable;
		logic       reserved;
		logic       prescale_select;
		logic [3:0] postscale_select;
	} wwdt_cfg_t;

	typedef struct packed {
		logic clear_watchdog_instr;
		logic power_save_instr;
		logic power_save_idle;
		logic exit_low_power;
		logic clock_switch_done;
	} wwdt_cpu_evt_t;

	typedef enum logic [1:0] {
		WWDT_RUN   = 2'b00,
		WWDT_SLEEP = 2'b01,
		WWDT_IDLE  = 2'b10
	} wwdt_pmode_t;

endpackage : wwdt_pkg

// ### logic/wwdt_low_power_rc_osc_osc.sv
// wwdt_low_power_rc_osc_osc: low-power rc oscillator model, one tick pulse per 32 kHz period
// assumes pclk at the rate given in the package
`timescale 1ns/1ps
module wwdt_low_power_rc_osc_osc (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic enable,
	output logic      tick
);
	logic [wwdt_pkg::LOW_POWER_RC_OSC_DIV_W-1:0] div_q;
	localparam logic [wwdt_pkg::LOW_POWER_RC_OSC_DIV_W-1:0] DIV_LAST =
		wwdt_pkg::LOW_POWER_RC_OSC_DIV_W'(wwdt_pkg::LOW_POWER_RC_OSC_DIV_CYCLES - 1);

	// oscillator stopped and phase reset while disabled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_q <= '0;
			tick  <= 1'b0;
		end
		else if (!enable)
		begin
			div_q <= '0;
			tick  <= 1'b0;
		end
		else
		begin
			tick  <= (div_q == DIV_LAST);
			div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
		end
	end
endmodule : wwdt_low_power_rc_osc_osc

// ### logic/wwdt_top.sv
// wwdt_top: windowed watchdog timer with apb registers and one level interrupt
// assumes cpu events are one-cycle pulses synchronous to pclk
//
// Contract
// - counter runs from low_power_rc_osc, enable starts low_power_rc_osc
// - prescaler divides by 32 or 128
// - four-bit postscaler, sixteen ratios
// - clear chain on reset and clock switch
// - clear chain on sleep, wake, clear instruction
// - keeps counting in sleep and idle
// - timeout in low power wakes core
// - sticky timeout flag, software clears it
// - hard enable forces watchdog on
// - otherwise soft enable bit runs it
// - any device reset clears soft enable
// - early clear in window mode resets device
// - prescale select one means divide 128
// - window disable one means no window
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
module wwdt_top (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire wwdt_pkg::wwdt_cpu_evt_t cpu_evt,
	output logic                       low_power_rc_osc_en,
	output logic                       device_reset,
	output logic                       wake,
	output logic                       irq
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	wwdt_pkg::wwdt_cfg_t            cfg_q;
	logic                           soft_enable_q;
	logic                           timeout_flag_q;
	logic                           sleep_flag_q;
	logic                           idle_flag_q;
	wwdt_pkg::wwdt_pmode_t          pmode_q;
	logic [wwdt_pkg::ELAPSED_W-1:0] elapsed_q;
	logic [wwdt_pkg::ST_W-1:0]      status_q;
	logic [wwdt_pkg::ST_W-1:0]      mask_q;
	logic                           low_power_rc_osc_tick;
	logic                           run;
	logic                           timeout;
	logic                           win_violation;
	logic                           chain_clear;
	logic                           apb_write;
	logic [4:0]                     shift;
	logic [wwdt_pkg::ELAPSED_W-1:0] period;
	logic [wwdt_pkg::ELAPSED_W-1:0] period_m1;
	logic [wwdt_pkg::ELAPSED_W-1:0] win_start;
	logic [wwdt_pkg::ST_W-1:0]      st_set;
	logic [31:0]                    rd_mux;
	logic                           addr_hit;

	////////////////////////////////////////////////////////////////////////////////
	// oscillator and enables
	assign run = cfg_q.hard_enable | soft_enable_q;

	wwdt_low_power_rc_osc_osc u_low_power_rc_osc (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (run),
		.tick    (low_power_rc_osc_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// period arithmetic
	always_comb
	begin
		shift = cfg_q.prescale_select ? 5'(wwdt_pkg::PRESCALE_128_LOG)
		                              : 5'(wwdt_pkg::PRESCALE_32_LOG);
		period    = 23'h000001 << (shift + 5'(cfg_q.postscale_select));
		period_m1 = period - 23'h000001;
		win_start = period - (period >> 2);
	end

	assign timeout       = run && low_power_rc_osc_tick && (elapsed_q == period_m1);
	assign win_violation = cpu_evt.clear_watchdog_instr && run && !cfg_q.window_disable
	                       && (elapsed_q < win_start);
	assign chain_clear   = cpu_evt.clear_watchdog_instr || cpu_evt.power_save_instr
	                       || cpu_evt.exit_low_power || cpu_evt.clock_switch_done
	                       || device_reset || (timeout && pmode_q != wwdt_pkg::WWDT_RUN);

	////////////////////////////////////////////////////////////////////////////////
	// prescaler and postscaler chain
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			elapsed_q <= '0;
		else if (chain_clear || !run)
			elapsed_q <= '0;
		else if (low_power_rc_osc_tick)
			elapsed_q <= timeout ? '0 : elapsed_q + 23'h000001;
	end

	////////////////////////////////////////////////////////////////////////////////
	// power mode tracking
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pmode_q <= wwdt_pkg::WWDT_RUN;
		else
		begin
			case (pmode_q)
				wwdt_pkg::WWDT_RUN:
				begin
					if (cpu_evt.power_save_instr)
						pmode_q <= cpu_evt.power_save_idle ? wwdt_pkg::WWDT_IDLE : wwdt_pkg::WWDT_SLEEP;
				end
				wwdt_pkg::WWDT_SLEEP, wwdt_pkg::WWDT_IDLE:
				begin
					if (timeout || cpu_evt.exit_low_power || device_reset)
						pmode_q <= wwdt_pkg::WWDT_RUN;
				end
				default:
					pmode_q <= wwdt_pkg::WWDT_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset and wake outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			device_reset <= 1'b0;
			wake         <= 1'b0;
		end
		else
		begin
			device_reset <= (timeout && pmode_q == wwdt_pkg::WWDT_RUN) || win_violation;
			wake         <= timeout && pmode_q != wwdt_pkg::WWDT_RUN;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			low_power_rc_osc_en <= 1'b0;
		else
			low_power_rc_osc_en <= run;
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb slave
	assign apb_write = psel && penable && pready && pwrite;

	always_comb
	begin
		addr_hit = 1'b1;
		rd_mux   = 32'h00000000;
		case (paddr)
			wwdt_pkg::OFS_CONFIG: rd_mux = {24'h000000, cfg_q};
			wwdt_pkg::OFS_RESET_CONTROL_REG:   rd_mux = {26'h0000000, soft_enable_q, timeout_flag_q,
			                                sleep_flag_q, idle_flag_q, 2'h0};
			wwdt_pkg::OFS_STATUS: rd_mux = {29'h00000000, status_q};
			wwdt_pkg::OFS_MASK:   rd_mux = {29'h00000000, mask_q};
			wwdt_pkg::OFS_COUNT:  rd_mux = {9'h000, elapsed_q};
			default:              addr_hit = 1'b0;
		endcase
	end

	// answer ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_hit;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration word and mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_q  <= wwdt_pkg::CONFIG_RESET;
			mask_q <= wwdt_pkg::MASK_RESET;
		end
		else if (apb_write)
		begin
			if (paddr == wwdt_pkg::OFS_CONFIG)
				cfg_q <= pwdata[7:0];
			if (paddr == wwdt_pkg::OFS_MASK)
				mask_q <= pwdata[wwdt_pkg::ST_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset control bits: hardware set, or device reset clearing soft enable, wins over software write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			soft_enable_q <= 1'b0;
		else if (device_reset)
			soft_enable_q <= 1'b0;
		else if (apb_write && paddr == wwdt_pkg::OFS_RESET_CONTROL_REG)
			soft_enable_q <= pwdata[wwdt_pkg::RESET_CONTROL_REG_SOFT_EN_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timeout_flag_q <= 1'b0;
		else if (timeout)
			timeout_flag_q <= 1'b1;
		else if (apb_write && paddr == wwdt_pkg::OFS_RESET_CONTROL_REG)
			timeout_flag_q <= timeout_flag_q & pwdata[wwdt_pkg::RESET_CONTROL_REG_TIMEOUT_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sleep_flag_q <= 1'b0;
			idle_flag_q  <= 1'b0;
		end
		else
		begin
			if (cpu_evt.power_save_instr && !cpu_evt.power_save_idle)
				sleep_flag_q <= 1'b1;
			else if (apb_write && paddr == wwdt_pkg::OFS_RESET_CONTROL_REG)
				sleep_flag_q <= sleep_flag_q & pwdata[wwdt_pkg::RESET_CONTROL_REG_SLEEP_BIT];
			if (cpu_evt.power_save_instr && cpu_evt.power_save_idle)
				idle_flag_q <= 1'b1;
			else if (apb_write && paddr == wwdt_pkg::OFS_RESET_CONTROL_REG)
				idle_flag_q <= idle_flag_q & pwdata[wwdt_pkg::RESET_CONTROL_REG_IDLE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status, write one to clear, set wins
	always_comb
	begin
		st_set = '0;
		st_set[wwdt_pkg::ST_TIMEOUT_BIT] = timeout;
		st_set[wwdt_pkg::ST_WINDOW_BIT]  = win_violation;
		st_set[wwdt_pkg::ST_WAKE_BIT]    = timeout && pmode_q != wwdt_pkg::WWDT_RUN;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_q <= '0;
		else if (apb_write && paddr == wwdt_pkg::OFS_STATUS)
			status_q <= st_set | (status_q & ~pwdata[wwdt_pkg::ST_W-1:0]);
		else
			status_q <= st_set | status_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(status_q & mask_q);
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	property p_osc_follows_enable;
		@(posedge pclk) disable iff (!presetn)
		run |=> low_power_rc_osc_en;
	endproperty
	a_osc_follows_enable: assert property (p_osc_follows_enable)
		else $error("low_power_rc_osc enable not following watchdog enable");

	property p_hard_enable_runs;
		@(posedge pclk) disable iff (!presetn)
		cfg_q.hard_enable ##1 cfg_q.hard_enable |-> low_power_rc_osc_en;
	endproperty
	a_hard_enable_runs: assert property (p_hard_enable_runs)
		else $error("watchdog stopped while hard enable set");

	property p_disabled_stops;
		@(posedge pclk) disable iff (!presetn)
		(!cfg_q.hard_enable && !soft_enable_q) |=> !low_power_rc_osc_en && elapsed_q == '0;
	endproperty
	a_disabled_stops: assert property (p_disabled_stops)
		else $error("watchdog running while both enables clear");

	property p_clear_instr_clears;
		@(posedge pclk) disable iff (!presetn)
		(cpu_evt.clear_watchdog_instr || cpu_evt.power_save_instr) |=> elapsed_q == '0;
	endproperty
	a_clear_instr_clears: assert property (p_clear_instr_clears)
		else $error("chain not cleared by clear or power save");

	property p_switch_clears;
		@(posedge pclk) disable iff (!presetn)
		cpu_evt.clock_switch_done |=> elapsed_q == '0;
	endproperty
	a_switch_clears: assert property (p_switch_clears)
		else $error("chain not cleared by clock switch");

	property p_counts_in_low_power;
		@(posedge pclk) disable iff (!presetn)
		(pmode_q != wwdt_pkg::WWDT_RUN && run && low_power_rc_osc_tick && !chain_clear && !timeout)
		|=> elapsed_q == $past(elapsed_q) + 23'h000001;
	endproperty
	a_counts_in_low_power: assert property (p_counts_in_low_power)
		else $error("chain not advancing in sleep or idle");

	property p_timeout_at_ratio;
		@(posedge pclk) disable iff (!presetn)
		timeout |-> elapsed_q == (23'h000001 << (5'(cfg_q.prescale_select ? 7 : 5)
		                          + 5'(cfg_q.postscale_select))) - 23'h000001;
	endproperty
	a_timeout_at_ratio: assert property (p_timeout_at_ratio)
		else $error("timeout at wrong prescale and postscale count");

	property p_wake_in_low_power;
		@(posedge pclk) disable iff (!presetn)
		(timeout && pmode_q != wwdt_pkg::WWDT_RUN) |=> wake && !device_reset
		                                               && pmode_q == wwdt_pkg::WWDT_RUN;
	endproperty
	a_wake_in_low_power: assert property (p_wake_in_low_power)
		else $error("low power timeout did not wake");

	property p_normal_timeout_resets;
		@(posedge pclk) disable iff (!presetn)
		(timeout && pmode_q == wwdt_pkg::WWDT_RUN) |=> device_reset && timeout_flag_q ##1 !soft_enable_q;
	endproperty
	a_normal_timeout_resets: assert property (p_normal_timeout_resets)
		else $error("normal timeout did not reset and flag");

	property p_flag_sticky;
		@(posedge pclk) disable iff (!presetn)
		(timeout_flag_q && !(apb_write && paddr == wwdt_pkg::OFS_RESET_CONTROL_REG)) |=> timeout_flag_q;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("timeout flag cleared itself");

	property p_early_clear_resets;
		@(posedge pclk) disable iff (!presetn)
		(cpu_evt.clear_watchdog_instr && run && !cfg_q.window_disable
		 && elapsed_q < (period >> 1)) |=> device_reset;
	endproperty
	a_early_clear_resets: assert property (p_early_clear_resets)
		else $error("early clear in window mode not punished");

	property p_nowindow_no_reset;
		@(posedge pclk) disable iff (!presetn)
		(cpu_evt.clear_watchdog_instr && cfg_q.window_disable && !timeout) |=> !device_reset;
	endproperty
	a_nowindow_no_reset: assert property (p_nowindow_no_reset)
		else $error("clear in non-window mode caused reset");

	property p_reset_clears_soft;
		@(posedge pclk) disable iff (!presetn)
		device_reset |=> !soft_enable_q && elapsed_q == '0;
	endproperty
	a_reset_clears_soft: assert property (p_reset_clears_soft)
		else $error("device reset left soft enable or count");

	c_normal_timeout: cover property (@(posedge pclk) disable iff (!presetn)
		timeout && pmode_q == wwdt_pkg::WWDT_RUN);
	c_wake: cover property (@(posedge pclk) disable iff (!presetn) wake);
	c_window_violation: cover property (@(posedge pclk) disable iff (!presetn) win_violation);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule : wwdt_top

// ### bench/wwdt_top_bench.sv
// wwdt_top_bench: self-checking bench for the windowed watchdog timer
// assumes wait-free apb slave and one-cycle cpu event pulses on pclk
`timescale 1ns/1ps
module wwdt_top_bench;
	localparam int T = wwdt_pkg::LOW_POWER_RC_OSC_DIV_CYCLES;
	logic                    pclk;
	logic                    presetn;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [7:0]              paddr;
	logic [31:0]             pwdata;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	wwdt_pkg::wwdt_cpu_evt_t cpu_evt;
	logic                    osc_en;
	logic                    device_reset;
	logic                    wake;
	logic                    irq;
	int                      fails;
	int                      checked;
	int                      n;
	logic [1:0]              ev;
	logic [31:0]             rd;
	logic                    err;
	logic [7:0]              cfg [2] = '{8'hC1, 8'h50};
	int                      tk [2]  = '{64, 128};

	wwdt_top u_wwdt_top (
		.pclk                (pclk),
		.presetn             (presetn),
		.psel                (psel),
		.penable             (penable),
		.pwrite              (pwrite),
		.paddr               (paddr),
		.pwdata              (pwdata),
		.prdata              (prdata),
		.pready              (pready),
		.pslverr             (pslverr),
		.cpu_evt             (cpu_evt),
		.low_power_rc_osc_en (osc_en),
		.device_reset        (device_reset),
		.wake                (wake),
		.irq                 (irq)
	);

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic close_out;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// one apb transfer, request held until pready seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			chk("pready", pready, 1);
	endtask : xfer

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
		xfer(1'b0, a, 32'h0);
		chk(name, rd, exp);
	endtask : rchk

	task automatic pulse(input logic [4:0] v);
		@(posedge pclk);
		cpu_evt <= wwdt_pkg::wwdt_cpu_evt_t'(v);
		@(posedge pclk);
		cpu_evt <= '0;
	endtask : pulse

	// cycles until device_reset or wake, at most max
	task automatic run(input int max, output int cnt, output logic [1:0] e);
		cnt = 0;
		e = 2'b00;
		while (cnt < max && e == 2'b00)
		begin
			@(posedge pclk);
			cnt++;
			e = {device_reset, wake};
		end
	endtask : run

	////////////////////////////////////////////////////////////////////////////////
	// watchdog against a hang
	initial
	begin
		repeat (100000) @(posedge pclk);
		fails++;
		$display("[FAIL] run expected done seen hang");
		close_out();
	end

	////////////////////////////////////////////////////////////////////////////////
	// tests
	initial
	begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		cpu_evt = '0;
		fails   = 0;
		checked = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;

		rchk(wwdt_pkg::OFS_CONFIG, 32'h7F, "config");
		rchk(wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h0, "reset_control_reg");
		rchk(wwdt_pkg::OFS_STATUS, 32'h0, "status");
		rchk(wwdt_pkg::OFS_MASK, 32'h0, "mask");
		rchk(wwdt_pkg::OFS_COUNT, 32'h0, "count");
		xfer(1'b0, 8'h14, 32'h0);
		chk("unmapped data", rd, 32'h0);
		chk("unmapped err", err, 1);
		chk("osc off", osc_en, 0);
		$display("test reset done");

		// running timeouts: hard enable post 1, then soft enable pre 128
		for (int i = 0; i < 2; i++)
		begin
			xfer(1'b1, wwdt_pkg::OFS_CONFIG, {24'h0, cfg[i]});
			if (i == 1)
				xfer(1'b1, wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h20);
			run(tk[i] * T + 400, n, ev);
			chk("reset evt", ev, 2'b10);
			chk("period", n >= (tk[i] - 1) * T && n <= tk[i] * T + 12, 1);
			rchk(wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h10, "reset_control_reg flag");
			xfer(1'b1, wwdt_pkg::OFS_CONFIG, 32'h40);
			rchk(wwdt_pkg::OFS_STATUS, 32'h1, "status");
			chk("irq masked", irq, 0);
			xfer(1'b1, wwdt_pkg::OFS_MASK, 32'h1);
			repeat (2) @(posedge pclk);
			chk("irq", irq, 1);
			xfer(1'b1, wwdt_pkg::OFS_STATUS, 32'h1);
			repeat (2) @(posedge pclk);
			chk("irq clr", irq, 0);
			xfer(1'b1, wwdt_pkg::OFS_MASK, 32'h0);
			rchk(wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h10, "flag sticky");
			xfer(1'b1, wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h0);
			rchk(wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h0, "flag clr");
		end
		$display("test timeout done");

		// clears keep it alive, then timeout in sleep wakes
		xfer(1'b1, wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h20);
		repeat (2) @(posedge pclk);
		chk("osc on", osc_en, 1);
		// two spans together outlast the 32-tick period, so a missed clear times out
		run(6000, n, ev);
		pulse(5'h01);
		rchk(wwdt_pkg::OFS_COUNT, 32'h0, "count switch");
		run(6000, n, ev);
		chk("no evt switch", ev, 2'b00);
		pulse(5'h10);
		rchk(wwdt_pkg::OFS_COUNT, 32'h0, "count clear");
		run(6000, n, ev);
		chk("no evt clear", ev, 2'b00);
		pulse(5'h08);
		run(32 * T + 400, n, ev);
		chk("wake evt", ev, 2'b01);
		chk("sleep period", n >= 31 * T && n <= 32 * T + 12, 1);
		rchk(wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h38, "reset_control_reg wake");
		xfer(1'b1, wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h20);
		rchk(wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h20, "reset_control_reg sw clr");
		rchk(wwdt_pkg::OFS_STATUS, 32'h5, "status wake");
		pulse(5'h02);
		rchk(wwdt_pkg::OFS_COUNT, 32'h0, "count exit");
		pulse(5'h0C);
		rchk(wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h24, "reset_control_reg idle");
		pulse(5'h02);
		xfer(1'b1, wwdt_pkg::OFS_STATUS, 32'h7);
		xfer(1'b1, wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h0);
		$display("test sleep done");

		// window mode: late clear accepted, early clear resets
		xfer(1'b1, wwdt_pkg::OFS_CONFIG, 32'h00);
		xfer(1'b1, wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h20);
		run(28 * T, n, ev);
		chk("no evt window", ev, 2'b00);
		pulse(5'h10);
		run(40, n, ev);
		chk("late clear", ev, 2'b00);
		rchk(wwdt_pkg::OFS_STATUS, 32'h0, "status late");
		pulse(5'h10);
		run(4, n, ev);
		chk("early clear", ev, 2'b10);
		rchk(wwdt_pkg::OFS_STATUS, 32'h2, "status early");
		rchk(wwdt_pkg::OFS_RESET_CONTROL_REG, 32'h0, "reset_control_reg early");
		$display("test window done");
		close_out();
	end
endmodule : wwdt_top_bench
